// >>> rtl/vectored_irq_pkg.sv
// Shared constants and types of the vectored interrupt controller
package vectored_irq_pkg;
	// ==========================================================
	// Sizes
	localparam int           NUM_IRQ      = 32;
	localparam int           IRQ_IDX_W    = 5;
	localparam int           PRIO_W       = 2;
	localparam int           NUM_LEVELS   = 5;
	localparam logic [2:0]   LEVEL_NONE   = 3'h5;
	// ==========================================================
	// Vectors (plain defaults)
	localparam logic [5:0]   NMI_VEC      = 6'h00;
	localparam logic [5:0]   IRQ_VEC_BASE = 6'h10;
	// ==========================================================
	// Timing
	localparam int           CLK_PERIOD_NS  = 10;
	localparam int           FIX_LAT_NS     = 160;
	localparam int           FIX_LAT_CYCLES = FIX_LAT_NS / CLK_PERIOD_NS;
	localparam logic [7:0]   FIX_LAT_LAST   = 8'(FIX_LAT_CYCLES - 1);
	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {
		S_IDLE,
		S_STACK,
		S_UNSTACK
	} seq_state_t;
endpackage

// >>> rtl/irq_priority_pick.sv
// Picks the winning pending channel by level, then by channel number
`timescale 1ns/100ps
module irq_priority_pick (
	// Requests and their levels
	input  wire logic [31:0] req,
	input  wire logic [63:0] prio,
	// Winner
	output logic             found,
	output logic [4:0]       idx,
	output logic [1:0]       level
);
	always_comb begin
		found = 1'b0;
		idx   = 5'h00;
		level = 2'h0;
		// Lower level number wins, then lowest channel
		for (int l = 0; l < 4; l++) begin
			for (int i = vectored_irq_pkg::NUM_IRQ - 1; i >= 0; i--) begin
				if (!found && req[i] && (prio[2*i +: 2] == 2'(l))) begin
					idx   = 5'(i);
					level = 2'(l);
				end
			end
			if (!found) begin
				for (int i = 0; i < vectored_irq_pkg::NUM_IRQ; i++) begin
					if (req[i] && (prio[2*i +: 2] == 2'(l)))
						found = 1'b1;
				end
			end
		end
	end
endmodule // irq_priority_pick

// >>> rtl/nested_vector_irq_ctrl.sv
// Nested vectored interrupt controller with stacking, tail chaining and sleep
`timescale 1ns/100ps
module nested_vector_irq_ctrl (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Peripheral requests
	input  wire logic [31:0] irq_in,
	input  wire logic        nmi_in,
	// Control levels
	input  wire logic [31:0] irq_enable,
	input  wire logic [63:0] irq_prio,
	input  wire logic        const_latency_mode,
	input  wire logic        deep_sleep_sel,
	input  wire logic        sleep_req,
	// Core sequencer handshake
	input  wire logic        core_multi_busy,
	input  wire logic        stack_done,
	input  wire logic        unstack_done,
	input  wire logic        handler_done,
	output logic             stack_req,
	output logic             unstack_req,
	output logic             entry_valid,
	output logic [5:0]       entry_vector,
	output logic             tail_chain,
	output logic             abandon_multi,
	output logic [2:0]       active_level,
	// Power
	output logic             sleep_deep,
	output logic             sleep_light,
	output logic             wake
);
	typedef struct packed {
		vectored_irq_pkg::seq_state_t state;
		logic [31:0]                  pend;
		logic                         nmi_pend;
		logic [4:0]                   active;
		logic [5:0]                   vec;
		logic [2:0]                   vlev;
		logic [7:0]                   cnt;
		logic                         done_seen;
		logic                         entry;
		logic                         tail;
		logic                         abandon;
		logic                         deep;
		logic                         light;
		logic                         wake;
	} ctrl_t;

	ctrl_t ctrl_reg;
	ctrl_t ctrl_next;

	logic       pick_found;
	logic [4:0] pick_idx;
	logic [1:0] pick_level;
	logic       cand_valid;
	logic [2:0] cand_level;
	logic [5:0] cand_vec;
	logic [2:0] cur_level;
	logic [4:0] popped;
	logic [2:0] popped_level;
	logic       take;
	logic       chain;
	logic       wake_cond;

	// ==========================================================
	// Level helpers: bit 0 is NMI, bits 1..4 are levels 0..3
	function automatic logic [2:0] lowest_level(input logic [4:0] m);
		logic [2:0] r;
		r = vectored_irq_pkg::LEVEL_NONE;
		for (int k = vectored_irq_pkg::NUM_LEVELS - 1; k >= 0; k--) begin
			if (m[k])
				r = 3'(k);
		end
		return r;
	endfunction

	function automatic logic [4:0] level_bit(input logic [2:0] l);
		return 5'(5'h01 << l);
	endfunction

	// ==========================================================
	// Arbitration
	irq_priority_pick u_pick (
		.req   (ctrl_reg.pend & irq_enable),
		.prio  (irq_prio),
		.found (pick_found),
		.idx   (pick_idx),
		.level (pick_level)
	);

	always_comb begin
		// NMI ignores masking and outranks all channels
		if (ctrl_reg.nmi_pend) begin
			cand_valid = 1'b1;
			cand_level = 3'h0;
			cand_vec   = vectored_irq_pkg::NMI_VEC;
		end else begin
			cand_valid = pick_found;
			cand_level = 3'({1'b0, pick_level} + 3'h1);
			cand_vec   = 6'(vectored_irq_pkg::IRQ_VEC_BASE + {1'b0, pick_idx});
		end
		cur_level    = lowest_level(ctrl_reg.active);
		popped       = ctrl_reg.active & ~level_bit(cur_level);
		popped_level = lowest_level(popped);
		// Only a strictly higher level pre-empts
		take  = (ctrl_reg.state == vectored_irq_pkg::S_IDLE) && !handler_done
		        && cand_valid && (cand_level < cur_level);
		// Next handler entered straight from the old one
		chain = (ctrl_reg.state == vectored_irq_pkg::S_IDLE) && handler_done
		        && (ctrl_reg.active != 5'h00) && cand_valid && (cand_level < popped_level);
		wake_cond = ctrl_reg.nmi_pend || ((ctrl_reg.pend & irq_enable) != 32'h0);
	end

	// ==========================================================
	// Next state
	always_comb begin
		ctrl_next         = ctrl_reg;
		ctrl_next.entry   = 1'b0;
		ctrl_next.tail    = 1'b0;
		ctrl_next.abandon = 1'b0;
		ctrl_next.wake    = 1'b0;
		// Masked lines never pend; new request beats the clear
		ctrl_next.pend     = ctrl_reg.pend | (irq_in & irq_enable);
		ctrl_next.nmi_pend = ctrl_reg.nmi_pend | nmi_in;

		case (ctrl_reg.state)
			vectored_irq_pkg::S_IDLE: begin
				if (take) begin
					ctrl_next.state     = vectored_irq_pkg::S_STACK;
					ctrl_next.vec       = cand_vec;
					ctrl_next.vlev      = cand_level;
					ctrl_next.cnt       = 8'h00;
					ctrl_next.done_seen = 1'b0;
					// Multi-register transfer dropped, core reissues it later
					ctrl_next.abandon   = core_multi_busy;
				end else if (chain) begin
					ctrl_next.active = popped | level_bit(cand_level);
					ctrl_next.vec    = cand_vec;
					ctrl_next.entry  = 1'b1;
					ctrl_next.tail   = 1'b1;
					if (cand_level == 3'h0)
						ctrl_next.nmi_pend = nmi_in;
					else
						ctrl_next.pend[pick_idx] = irq_in[pick_idx] & irq_enable[pick_idx];
				end else if (handler_done && (ctrl_reg.active != 5'h00)) begin
					// Frame restored so the handler returns like a function
					ctrl_next.active = popped;
					ctrl_next.state  = vectored_irq_pkg::S_UNSTACK;
				end
			end
			vectored_irq_pkg::S_STACK: begin
				if (ctrl_reg.cnt != 8'hFF)
					ctrl_next.cnt = 8'(ctrl_reg.cnt + 8'h01);
				if (stack_done)
					ctrl_next.done_seen = 1'b1;
				// Pad to a fixed count when constant latency is chosen
				if ((stack_done || ctrl_reg.done_seen)
				    && (!const_latency_mode || (ctrl_reg.cnt >= vectored_irq_pkg::FIX_LAT_LAST))) begin
					ctrl_next.state  = vectored_irq_pkg::S_IDLE;
					ctrl_next.entry  = 1'b1;
					ctrl_next.active = ctrl_reg.active | level_bit(ctrl_reg.vlev);
					if (ctrl_reg.vlev == 3'h0)
						ctrl_next.nmi_pend = nmi_in;
					else
						ctrl_next.pend[5'(ctrl_reg.vec - vectored_irq_pkg::IRQ_VEC_BASE)] =
							irq_in[5'(ctrl_reg.vec - vectored_irq_pkg::IRQ_VEC_BASE)]
							& irq_enable[5'(ctrl_reg.vec - vectored_irq_pkg::IRQ_VEC_BASE)];
				end
			end
			vectored_irq_pkg::S_UNSTACK: begin
				if (unstack_done)
					ctrl_next.state = vectored_irq_pkg::S_IDLE;
			end
			default: begin
				ctrl_next.state = vectored_irq_pkg::S_IDLE;
			end
		endcase

		// Sleep entry and wake-up
		if ((ctrl_reg.deep || ctrl_reg.light) && wake_cond) begin
			ctrl_next.deep  = 1'b0;
			ctrl_next.light = 1'b0;
			ctrl_next.wake  = 1'b1;
		end else if (sleep_req && !wake_cond && !ctrl_reg.deep && !ctrl_reg.light) begin
			ctrl_next.deep  = deep_sleep_sel;
			ctrl_next.light = !deep_sleep_sel;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ==========================================================
	// Outputs
	assign stack_req     = (ctrl_reg.state == vectored_irq_pkg::S_STACK);
	assign unstack_req   = (ctrl_reg.state == vectored_irq_pkg::S_UNSTACK);
	assign entry_valid   = ctrl_reg.entry;
	assign entry_vector  = ctrl_reg.vec;
	assign tail_chain    = ctrl_reg.tail;
	assign abandon_multi = ctrl_reg.abandon;
	assign active_level  = cur_level;
	assign sleep_deep    = ctrl_reg.deep;
	assign sleep_light   = ctrl_reg.light;
	assign wake          = ctrl_reg.wake;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_req_start;
		$rose(stack_req) && const_latency_mode;
	endsequence
	// Fixed span of 16: request held 15 more cycles, stacking already done
	sequence s_fast_done;
		(stack_req && const_latency_mode) [*8] ##1 (stack_req && const_latency_mode) [*7]
		##0 (stack_done || ctrl_reg.done_seen);
	endsequence

	AST_MASK_BLOCKS: assert property ((ctrl_next.pend & ~ctrl_reg.pend & ~irq_enable) == 32'h0)
		else $error("masked line became pending");
	AST_PREEMPT: assert property ((entry_valid && !tail_chain) |-> active_level < $past(active_level))
		else $error("pre-emption wrong");
	AST_NMI_FIRST: assert property ((take && ctrl_reg.nmi_pend)
		|=> entry_vector == vectored_irq_pkg::NMI_VEC) else $error("NMI not first");
	AST_CONST_LAT: assert property ((s_req_start ##1 s_fast_done) |=> entry_valid)
		else $error("latency not constant");
	AST_STACK_ENTRY: assert property ((stack_req && stack_done && !const_latency_mode)
		|=> entry_valid && !stack_req) else $error("entry after stacking late");
	AST_ABANDON: assert property ((take && core_multi_busy) |=> abandon_multi && stack_req)
		else $error("multi transfer not abandoned");
	AST_TAIL: assert property (tail_chain |-> entry_valid && !stack_req && !unstack_req
		&& $past(handler_done)) else $error("tail chain restacked");
	AST_RETURN: assert property ((handler_done && ctrl_reg.state == vectored_irq_pkg::S_IDLE
		&& ctrl_reg.active != 5'h00 && !chain) |=> unstack_req) else $error("no unstack");
	AST_DEEP: assert property ((sleep_req && deep_sleep_sel && !wake_cond && !sleep_light && !sleep_deep)
		|=> sleep_deep ##0 !sleep_light) else $error("deep sleep not entered");
	AST_WAKE: assert property ((sleep_deep && wake_cond) |=> wake && !sleep_deep)
		else $error("no wake");
	AST_ORDER: assert property ((take && !ctrl_reg.nmi_pend && pick_idx != 5'h00)
		|-> !(irq_enable[0] && ctrl_reg.pend[0] && irq_prio[1:0] == pick_level))
		else $error("lower channel skipped");
endmodule // nested_vector_irq_ctrl

// >>> tb/core_seq_model.sv
// Behavioural model of the core's exception sequencer
`timescale 1ns/100ps
module core_seq_model (
	// Clock and pacing
	input  wire logic       clk_sys,
	input  wire logic [3:0] delay,
	// Requests from the controller
	input  wire logic       stack_req,
	input  wire logic       unstack_req,
	// Completion pulses
	output logic            stack_done,
	output logic            unstack_done
);
	int cnt_s = 0;
	int cnt_u = 0;

	initial begin
		stack_done = 1'b0;
		unstack_done = 1'b0;
	end

	// Parked at -1 so a request that is still held is answered once only
	always @(negedge clk_sys) begin
		cnt_s = stack_req ? ((cnt_s < 0) ? cnt_s : cnt_s + 1) : 0;
		cnt_u = unstack_req ? ((cnt_u < 0) ? cnt_u : cnt_u + 1) : 0;
		stack_done = (cnt_s == int'(delay));
		unstack_done = (cnt_u == int'(delay));
		if (stack_done) cnt_s = -1;
		if (unstack_done) cnt_u = -1;
	end
endmodule // core_seq_model

// >>> tb/tb.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/100ps
module tb;
	// ==========================================================
	// Stimulus and observed signals
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] irq_in = '0;
	logic        nmi_in = 1'b0;
	logic [31:0] irq_enable = '1;
	logic [63:0] irq_prio = '0;
	logic        const_latency_mode = 1'b0;
	logic        deep_sleep_sel = 1'b0;
	logic        sleep_req = 1'b0;
	logic        core_multi_busy = 1'b0;
	logic        handler_done = 1'b0;
	logic [3:0]  delay = 4'h3;
	logic        stack_done, unstack_done, stack_req, unstack_req, entry_valid;
	logic        tail_chain, abandon_multi, sleep_deep, sleep_light, wake;
	logic [5:0]  entry_vector;
	logic [2:0]  active_level;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          lat;
	logic        ab, seen;

	always #5 clk_sys = ~clk_sys;

	nested_vector_irq_ctrl u_nested_vector_irq_ctrl (
		.clk_sys(clk_sys), .rst_n(rst_n), .irq_in(irq_in), .nmi_in(nmi_in), .irq_enable(irq_enable),
		.irq_prio(irq_prio), .const_latency_mode(const_latency_mode), .deep_sleep_sel(deep_sleep_sel),
		.sleep_req(sleep_req), .core_multi_busy(core_multi_busy), .stack_done(stack_done),
		.unstack_done(unstack_done), .handler_done(handler_done), .stack_req(stack_req),
		.unstack_req(unstack_req), .entry_valid(entry_valid), .entry_vector(entry_vector),
		.tail_chain(tail_chain), .abandon_multi(abandon_multi), .active_level(active_level),
		.sleep_deep(sleep_deep), .sleep_light(sleep_light), .wake(wake));

	core_seq_model u_core_seq_model (
		.clk_sys(clk_sys), .delay(delay), .stack_req(stack_req), .unstack_req(unstack_req),
		.stack_done(stack_done), .unstack_done(unstack_done));

	// ==========================================================
	// Shared tasks
	task automatic check_val(string name, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One-cycle pulse, so a cleared pending bit is not set again
	task automatic raise(logic [31:0] m, logic n);
		@(negedge clk_sys);
		irq_in = m;
		nmi_in = n;
		@(negedge clk_sys);
		irq_in = '0;
		nmi_in = 1'b0;
	endtask

	// Latency counts negedges from the first one showing stack_req
	task automatic wait_entry();
		int i;
		lat = 0;
		ab = 1'b0;
		seen = 1'b0;
		for (i = 0; i < 60 && !seen; i++) begin
			@(negedge clk_sys);
			if (stack_req && lat == 0) ab = abandon_multi;
			if (stack_req || lat > 0) lat++;
			seen = entry_valid;
		end
	endtask

	task automatic finish_handler();
		@(negedge clk_sys);
		handler_done = 1'b1;
		@(negedge clk_sys);
		handler_done = 1'b0;
	endtask

	task automatic ret_plain(logic [7:0] lvl);
		int i;
		finish_handler();
		check_val("unstack", 8'h01, 8'(unstack_req));
		check_val("tail", 8'h00, 8'(tail_chain));
		check_val("level", lvl, 8'(active_level));
		for (i = 0; i < 20 && unstack_req; i++) @(negedge clk_sys);
		check_val("unstack_end", 8'h00, 8'(unstack_req));
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_basic();
		irq_prio = 64'h0000_0000_0000_0040;
		raise(32'h0000_0008, 1'b0);
		wait_entry();
		check_val("vector", 8'h13, 8'(entry_vector));
		check_val("level", 8'h02, 8'(active_level));
		check_val("stack_lat", 8'(delay) + 8'h01, 8'(lat));
		check_val("abandon", 8'h00, 8'(ab));
		ret_plain(8'h05);
	endtask

	task automatic sc_mask();
		irq_enable = 32'hFFFF_FFDF;
		raise(32'h0000_0020, 1'b0);
		wait_entry();
		check_val("masked", 8'h00, 8'(seen));
		// A masked request must not be remembered once enabled again
		irq_enable = '1;
		wait_entry();
		check_val("masked_late", 8'h00, 8'(seen));
	endtask

	task automatic sc_nest();
		irq_prio = 64'h0000_0000_0000_4100;
		raise(32'h0000_0090, 1'b0);
		wait_entry();
		check_val("vector", 8'h14, 8'(entry_vector));
		raise(32'h0000_0200, 1'b0);
		wait_entry();
		check_val("vector", 8'h19, 8'(entry_vector));
		check_val("level", 8'h01, 8'(active_level));
		ret_plain(8'h02);
		finish_handler();
		check_val("tail", 8'h01, 8'(tail_chain & entry_valid));
		check_val("vector", 8'h17, 8'(entry_vector));
		check_val("unstack", 8'h00, 8'(unstack_req | stack_req));
		ret_plain(8'h05);
	endtask

	task automatic sc_nmi();
		irq_prio = '0;
		raise(32'h0000_0001, 1'b1);
		wait_entry();
		check_val("vector", 8'h00, 8'(entry_vector));
		check_val("level", 8'h00, 8'(active_level));
		finish_handler();
		check_val("vector", 8'h10, 8'(entry_vector & {6{tail_chain}}));
		ret_plain(8'h05);
	endtask

	task automatic sc_const();
		const_latency_mode = 1'b1;
		core_multi_busy = 1'b1;
		delay = 4'h2;
		raise(32'h0000_0008, 1'b0);
		wait_entry();
		check_val("fix_lat", 8'(vectored_irq_pkg::FIX_LAT_CYCLES + 1), 8'(lat));
		check_val("abandon", 8'h01, 8'(ab));
		const_latency_mode = 1'b0;
		core_multi_busy = 1'b0;
		ret_plain(8'h05);
	endtask

	task automatic sc_sleep();
		int i;
		for (i = 0; i < 2; i++) begin
			deep_sleep_sel = i[0];
			@(negedge clk_sys);
			sleep_req = 1'b1;
			@(negedge clk_sys);
			sleep_req = 1'b0;
			check_val("deep", 8'(i), 8'(sleep_deep));
			check_val("light", 8'(1 - i), 8'(sleep_light));
			irq_enable = 32'hFFFF_FFFB;
			raise(32'h0000_0004, 1'b0);
			@(negedge clk_sys);
			check_val("asleep", 8'h01, 8'(sleep_deep | sleep_light));
			irq_enable = '1;
			raise(32'h0000_0004, 1'b0);
			@(negedge clk_sys);
			check_val("wake", 8'h01, 8'(wake & ~sleep_deep & ~sleep_light));
			wait_entry();
			ret_plain(8'h05);
		end
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		sc_basic();
		sc_mask();
		sc_nest();
		sc_nmi();
		sc_const();
		sc_sleep();
		print_verdict();
	end

	// Tests need well under 2000 cycles
	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end
endmodule // tb
